/* File: atc_limit_check.sv */
// window limit checker for temperature and auxiliary conversion results
//
// Operation
// - temp code >= upper limit raises event
// - temp code <= lower limit raises event
// - first_auxiliary_input code >= upper limit raises event
// - first_auxiliary_input code <= lower limit raises event
// - second_auxiliary_input code >= upper limit raises event
// - second_auxiliary_input code <= lower limit raises event
// - temp upper check enable, bit 12
// - temp lower check enable, bit 12
// - first_auxiliary_input upper check enable, bit 12
// - first_auxiliary_input lower check enable, bit 12
// - second_auxiliary_input upper check enable, bit 12
// - second_auxiliary_input lower check enable, bit 12
// - auto scan: temp-select bit picks input
// - manual scan: scan-mode field picks input
// - pin enable routes interrupt to pin
// - readable upper and lower flags per channel
`include "atc_params.svh"

module atc_limit_check #(
    parameter int CODE_W = `ATC_LIMIT_W
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire atc_pkg::atc_reg_req_s i_reg,
    input wire atc_pkg::atc_conv_s i_conv,
    input wire logic i_auto_scan,
    input wire logic [`ATC_SCAN_MODE_W-1:0] i_converter_scan_mode,
    output logic [`ATC_DATA_W-1:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic o_limit_event,
    output logic o_irq_pin
);

    // ***************************************
    // parameter check
    // ***************************************
    // limit fields are fixed at 12 bits in the register map
    if (CODE_W != `ATC_LIMIT_W) begin : g_bad_width
        $error("atc_limit_check: CODE_W must equal the limit field width");
    end

    localparam atc_pkg::atc_state_s RESET_STATE = '{
        limit: {`ATC_LOWER_RESET, `ATC_UPPER_RESET, `ATC_LOWER_RESET,
                `ATC_UPPER_RESET, `ATC_LOWER_RESET, `ATC_UPPER_RESET},
        meas_cfg: `ATC_MEAS_CFG_RESET,
        flag: '0,
        rdata: '0,
        rvalid: 1'b0,
        limit_event: 1'b0,
        irq_pin: 1'b0
    };

    atc_pkg::atc_state_s cur;
    atc_pkg::atc_state_s next_s;

    // ***************************************
    // temperature input selection
    // ***************************************
    logic temp_sel_two;
    logic temp_checked;
    atc_pkg::atc_chan_e temp_chan;

    always_comb begin
        temp_sel_two = 1'b0;
        temp_checked = 1'b0;
        if (i_auto_scan) begin
            temp_sel_two = cur.meas_cfg[`ATC_TEMP_SEL_BIT];
            temp_checked = 1'b1;
        end else if (i_converter_scan_mode == `ATC_SCAN_TEMP_ONE) begin
            temp_checked = 1'b1;
        end else if (i_converter_scan_mode == `ATC_SCAN_TEMP_TWO) begin
            temp_sel_two = 1'b1;
            temp_checked = 1'b1;
        end
        temp_chan = temp_sel_two ? atc_pkg::ATC_CH_TEMP_TWO : atc_pkg::ATC_CH_TEMP_ONE;
    end

    // ***************************************
    // per channel comparison
    // ***************************************
    // limit index 2*ch is the upper limit, 2*ch+1 the lower one
    logic [`ATC_NUM_CHANNELS-1:0] conv_hit;
    logic [`ATC_NUM_LIMITS-1:0] cmp_hit;

    for (genvar ch = 0; ch < `ATC_NUM_CHANNELS; ch++) begin : g_chan
        atc_pkg::atc_chan_e want;
        logic ok;
        if (ch == 0) begin : g_temp
            assign want = temp_chan;
            assign ok = temp_checked;
        end else if (ch == 1) begin : g_first_aux
            assign want = atc_pkg::ATC_CH_FIRST_AUX;
            assign ok = 1'b1;
        end else begin : g_second_aux
            assign want = atc_pkg::ATC_CH_SECOND_AUX;
            assign ok = 1'b1;
        end
        // only a completed conversion of this channel is judged
        assign conv_hit[ch] = i_conv.valid && ok && (i_conv.chan == want);
        // unsigned compare, equal counts as reached on both sides
        assign cmp_hit[2*ch] = i_conv.code >= cur.limit[2*ch][`ATC_LIMIT_W-1:0];
        assign cmp_hit[2*ch+1] = i_conv.code <= cur.limit[2*ch+1][`ATC_LIMIT_W-1:0];
    end

    // ***************************************
    // next state
    // ***************************************
    logic [`ATC_ADDR_W-1:0] lim_idx;
    logic lim_sel;
    logic [`ATC_NUM_LIMITS-1:0] check_en;
    logic [`ATC_NUM_LIMITS-1:0] fired;
    logic [`ATC_NUM_LIMITS-1:0] next_check_en;

    always_comb begin
        next_s = cur;
        next_s.limit_event = 1'b0;
        next_s.rvalid = 1'b0;
        lim_idx = i_reg.addr - `ATC_REG_TEMP_UPPER;
        lim_sel = (i_reg.addr >= `ATC_REG_TEMP_UPPER) && (i_reg.addr <= `ATC_REG_SECOND_AUX_LOWER);
        check_en = '0;
        fired = '0;
        next_check_en = '0;

        // register writes
        if (i_reg.wr) begin
            if (lim_sel) begin
                // bits 15..13 are simply not stored
                next_s.limit[lim_idx[2:0]] = i_reg.wdata[`ATC_LIMIT_REG_W-1:0];
            end else if (i_reg.addr == `ATC_REG_MEAS_CFG) begin
                // flags are read only and survive the write
                next_s.meas_cfg = (cur.meas_cfg & ~`ATC_MEAS_CFG_WMASK)
                                | (i_reg.wdata & `ATC_MEAS_CFG_WMASK);
            end
        end

        // flags follow the latest conversion of their channel
        for (int k = 0; k < `ATC_NUM_LIMITS; k++) begin
            check_en[k] = cur.limit[k][`ATC_CHECK_EN_BIT];
            next_check_en[k] = next_s.limit[k][`ATC_CHECK_EN_BIT];
            if (conv_hit[k/2]) begin
                next_s.flag[k] = cmp_hit[k];
                fired[k] = cmp_hit[k] & check_en[k];
            end
        end
        next_s.limit_event = |fired;

        // pin holds while any enabled check stands failed
        // uses the enables of this edge, so a limit write moves the pin at once
        next_s.irq_pin = next_s.meas_cfg[`ATC_IRQ_PIN_EN_BIT]
                       & |(next_s.flag & next_check_en);

        // register reads, answered one cycle later
        if (i_reg.rd) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = '0;
            if (lim_sel) begin
                next_s.rdata = {3'h0, cur.limit[lim_idx[2:0]]};
            end else if (i_reg.addr == `ATC_REG_MEAS_CFG) begin
                next_s.rdata = cur.meas_cfg;
                for (int k = 0; k < `ATC_NUM_LIMITS; k++) begin
                    next_s.rdata[`ATC_FLAG_MSB-k] = cur.flag[k];
                end
            end
        end
    end

    // ***************************************
    // state register
    // ***************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur <= RESET_STATE;
        end else begin
            cur <= next_s;
        end
    end

    assign o_reg_rdata = cur.rdata;
    assign o_reg_rvalid = cur.rvalid;
    assign o_limit_event = cur.limit_event;
    assign o_irq_pin = cur.irq_pin;

endmodule

/* File: atc_params.svh */
// constants for the temperature and auxiliary limit checker
`ifndef ATC_PARAMS_SVH
`define ATC_PARAMS_SVH

// ***************************************
// register map
// ***************************************
`define ATC_ADDR_W 8
`define ATC_DATA_W 16
`define ATC_REG_TEMP_UPPER 8'h06
`define ATC_REG_TEMP_LOWER 8'h07
`define ATC_REG_FIRST_AUX_UPPER 8'h08
`define ATC_REG_FIRST_AUX_LOWER 8'h09
`define ATC_REG_SECOND_AUX_UPPER 8'h0A
`define ATC_REG_SECOND_AUX_LOWER 8'h0B
`define ATC_REG_MEAS_CFG 8'h0C

// ***************************************
// fields and reset values
// ***************************************
`define ATC_LIMIT_W 12
`define ATC_LIMIT_REG_W 13
`define ATC_CHECK_EN_BIT 12
`define ATC_UPPER_RESET 13'h0FFF
`define ATC_LOWER_RESET 13'h0000
`define ATC_MEAS_CFG_RESET 16'h0000
`define ATC_MEAS_CFG_WMASK 16'hDE04
`define ATC_TEMP_SEL_BIT 15
`define ATC_IRQ_PIN_EN_BIT 9
`define ATC_FLAG_MSB 8
`define ATC_NUM_LIMITS 6
`define ATC_NUM_CHANNELS 3

// ***************************************
// manual scan mode codes that convert a temperature input
// ***************************************
`define ATC_SCAN_MODE_W 4
`define ATC_SCAN_TEMP_ONE 4'hA
`define ATC_SCAN_TEMP_TWO 4'hB

`endif

/* File: atc_pkg.sv */
// types shared by the limit checker and its bench
`include "atc_params.svh"

package atc_pkg;

    // ***************************************
    // converter result source
    // ***************************************
    typedef enum logic [2:0] {
        ATC_CH_TEMP_ONE,
        ATC_CH_TEMP_TWO,
        ATC_CH_FIRST_AUX,
        ATC_CH_SECOND_AUX,
        ATC_CH_OTHER
    } atc_chan_e;

    typedef struct packed {
        logic valid;
        atc_chan_e chan;
        logic [`ATC_LIMIT_W-1:0] code;
    } atc_conv_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [`ATC_ADDR_W-1:0] addr;
        logic [`ATC_DATA_W-1:0] wdata;
    } atc_reg_req_s;

    // ***************************************
    // whole state of the checker
    // ***************************************
    typedef struct packed {
        logic [`ATC_NUM_LIMITS-1:0][`ATC_LIMIT_REG_W-1:0] limit;
        logic [`ATC_DATA_W-1:0] meas_cfg;
        logic [`ATC_NUM_LIMITS-1:0] flag;
        logic [`ATC_DATA_W-1:0] rdata;
        logic rvalid;
        logic limit_event;
        logic irq_pin;
    } atc_state_s;

endpackage

/* File: atc_host_model.sv */
// host side of the register port
module atc_host_model (
    input wire logic i_clk,
    output atc_pkg::atc_reg_req_s o_reg,
    input wire logic [15:0] i_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_reg = '0;
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge i_clk);
        o_reg <= '{1'b1, 1'b0, a, v};
        @(posedge i_clk);
        o_reg <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge i_clk);
        o_reg <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge i_clk);
        o_reg <= '0;
        #1;
        v = i_rdata;
    endtask
endmodule

/* File: atc_limit_check_checker.sv */
// port assertions for the limit checker
module atc_limit_check_checker (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire atc_pkg::atc_reg_req_s i_reg,
    input wire atc_pkg::atc_conv_s i_conv,
    input wire logic i_auto_scan,
    input wire logic [3:0] i_converter_scan_mode,
    input wire logic [15:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic o_limit_event,
    input wire logic o_irq_pin
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_read_answer: assert property (i_reg.rd |=> o_reg_rvalid)
        else $error("read not answered");
    a_rdata_holds: assert property (!i_reg.rd |=> $stable(o_reg_rdata) && !o_reg_rvalid)
        else $error("read data moved without read");
    a_limit_top_zero: assert property (i_reg.rd && i_reg.addr inside {[8'h06:8'h0B]} |=> o_reg_rdata[15:13] == 3'h0)
        else $error("limit top bits not zero");
    a_unmapped_zero: assert property (i_reg.rd && !(i_reg.addr inside {[8'h06:8'h0C]}) |=> o_reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_event_cause: assert property (!i_conv.valid |=> !o_limit_event)
        else $error("event without conversion");
    a_other_quiet: assert property (i_conv.valid && i_conv.chan == atc_pkg::ATC_CH_OTHER |=> !o_limit_event)
        else $error("event on unchecked source");
    a_manual_gate: assert property (i_conv.valid && !i_auto_scan && i_conv.chan inside {atc_pkg::ATC_CH_TEMP_ONE,
        atc_pkg::ATC_CH_TEMP_TWO} && !(i_converter_scan_mode inside {4'hA, 4'hB}) |=> !o_limit_event)
        else $error("temperature checked outside its scan mode");
    a_irq_cause: assert property ($changed(o_irq_pin) |-> $past(i_conv.valid || i_reg.wr))
        else $error("pin moved without cause");
    cover property (o_limit_event);
    cover property (o_irq_pin);
    cover property (i_reg.rd ##1 o_reg_rvalid);
endmodule

bind atc_limit_check atc_limit_check_checker atc_limit_check_checker_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_reg(i_reg), .i_conv(i_conv), .i_auto_scan(i_auto_scan), .i_converter_scan_mode(i_converter_scan_mode),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_limit_event(o_limit_event), .o_irq_pin(o_irq_pin));

/* File: test_aux_temp_threshold_compare.sv */
// self-checking bench for the limit checker
module test_aux_temp_threshold_compare;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_rst_n = 0, i_auto_scan = 0, o_reg_rvalid, o_limit_event, o_irq_pin;
    logic [3:0] i_converter_scan_mode = 4'h0;
    logic [15:0] o_reg_rdata, d;
    atc_pkg::atc_conv_s i_conv = '0;
    atc_pkg::atc_reg_req_s i_reg;
    int fail_count = 0, n_checks = 0, cyc = 0;
    initial forever #5 i_clk = ~i_clk;
    atc_host_model atc_host_model_inst (.i_clk(i_clk), .o_reg(i_reg), .i_rdata(o_reg_rdata));
    atc_limit_check atc_limit_check_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg(i_reg), .i_conv(i_conv),
        .i_auto_scan(i_auto_scan), .i_converter_scan_mode(i_converter_scan_mode), .o_reg_rdata(o_reg_rdata),
        .o_reg_rvalid(o_reg_rvalid), .o_limit_event(o_limit_event), .o_irq_pin(o_irq_pin));
    task automatic ck(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [15:0] v);
        atc_host_model_inst.wr(a, v);
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] exp);
        atc_host_model_inst.rd(a, d);
        ck({15'h0, o_reg_rvalid}, 16'h0001);
        ck(d, exp);
    endtask
    // event is judged in the cycle it stands
    task automatic cv(input atc_pkg::atc_chan_e ch, input logic [11:0] c, input logic ev);
        @(posedge i_clk);
        i_conv <= '{1'b1, ch, c};
        @(posedge i_clk);
        i_conv <= '0;
        #1;
        ck({15'h0, o_limit_event}, {15'h0, ev});
    endtask
    task automatic t_reset;
        for (int i = 0; i < 6; i++) begin
            rc(8'h06 + 8'(i), i[0] ? 16'h0000 : 16'h0FFF);
        end
        rc(8'h00, 16'h0000);
        w(8'h06, 16'hFFFF);
        rc(8'h06, 16'h1FFF);
    endtask
    task automatic t_aux;
        atc_pkg::atc_chan_e ch;
        logic [7:0] a;
        for (int i = 0; i < 2; i++) begin
            ch = (i == 1) ? atc_pkg::ATC_CH_SECOND_AUX : atc_pkg::ATC_CH_FIRST_AUX;
            a = 8'h08 + 8'(2 * i);
            cv(ch, 12'hFFF, 1'b0);
            w(a, 16'h1800);
            cv(ch, 12'h800, 1'b1);
            cv(ch, 12'h7FF, 1'b0);
            w(a + 8'h01, 16'h1100);
            cv(ch, 12'h100, 1'b1);
            cv(ch, 12'h101, 1'b0);
            w(a, 16'h0800);
            cv(ch, 12'h800, 1'b0);
        end
        // an unchecked source is never judged against a limit
        cv(atc_pkg::ATC_CH_OTHER, 12'h000, 1'b0);
    endtask
    task automatic t_temp;
        i_auto_scan <= 1'b1;
        w(8'h06, 16'h1400);
        w(8'h07, 16'h1010);
        cv(atc_pkg::ATC_CH_TEMP_ONE, 12'h400, 1'b1);
        cv(atc_pkg::ATC_CH_TEMP_TWO, 12'h400, 1'b0);
        w(8'h0C, 16'h8000);
        cv(atc_pkg::ATC_CH_TEMP_TWO, 12'h010, 1'b1);
        cv(atc_pkg::ATC_CH_TEMP_ONE, 12'h010, 1'b0);
        i_auto_scan <= 1'b0;
        i_converter_scan_mode <= 4'hA;
        cv(atc_pkg::ATC_CH_TEMP_ONE, 12'h400, 1'b1);
        cv(atc_pkg::ATC_CH_TEMP_TWO, 12'h400, 1'b0);
        i_converter_scan_mode <= 4'hB;
        cv(atc_pkg::ATC_CH_TEMP_TWO, 12'h400, 1'b1);
        i_converter_scan_mode <= 4'h0;
        cv(atc_pkg::ATC_CH_TEMP_TWO, 12'h400, 1'b0);
        i_converter_scan_mode <= 4'hB;
        cv(atc_pkg::ATC_CH_TEMP_TWO, 12'h200, 1'b0);
    endtask
    // pin is looked at one step after the edge that moves it
    task automatic t_irq;
        w(8'h0C, 16'h0200);
        #1;
        ck({15'h0, o_irq_pin}, 16'h0000);
        w(8'h08, 16'h1800);
        #1;
        ck({15'h0, o_irq_pin}, 16'h0001);
        cv(atc_pkg::ATC_CH_FIRST_AUX, 12'h500, 1'b0);
        ck({15'h0, o_irq_pin}, 16'h0000);
        cv(atc_pkg::ATC_CH_FIRST_AUX, 12'h900, 1'b1);
        ck({15'h0, o_irq_pin}, 16'h0001);
        atc_host_model_inst.rd(8'h0C, d);
        ck(d & 16'h0240, 16'h0240);
        w(8'h0C, 16'h0000);
        #1;
        ck({15'h0, o_irq_pin}, 16'h0000);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // a hang ends the run as a mismatch
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_aux();
        t_temp();
        t_irq();
        print_verdict();
    end
endmodule
